// file: hdl/pss_pkg.sv
// Shared constants and types for the program sequencer and return stack
`default_nettype none
package pss_pkg;
  localparam int PSS_PC_W = 12;
  localparam int PSS_PCL_W = 8;
  localparam int PSS_INSTR_W = 16;
  localparam int PSS_STK_DEPTH = 8;
  localparam int PSS_STK_PTR_W = 3;
  localparam int PSS_STK_CNT_W = 4;
  localparam int PSS_REG_ADDR_W = 4;
  localparam int PSS_OP_W = 3;

  // Reset vector and reset values
  localparam logic [11:0] PSS_RESET_VECTOR = 12'h000;
  localparam logic [7:0] PSS_PCL_RESET = 8'h00;
  localparam logic [15:0] PSS_INSTR_RESET = 16'h0000;

  // Phase one-hot codes; reset parks in the last phase so the first edge enters phase one
  localparam logic [3:0] PSS_PH_T1 = 4'h1;
  localparam logic [3:0] PSS_PH_T2 = 4'h2;
  localparam logic [3:0] PSS_PH_T3 = 4'h4;
  localparam logic [3:0] PSS_PH_T4 = 4'h8;
  localparam logic [3:0] PSS_PH_RESET = PSS_PH_T4;

  // Stack reset: pointer at the top, nothing in use
  localparam logic [2:0] PSS_STK_TOP_RESET = 3'h7;
  localparam logic [3:0] PSS_STK_CNT_RESET = 4'h0;
  localparam logic [3:0] PSS_STK_CNT_FULL = 4'h8;

  // Register map
  localparam logic [3:0] PSS_OFF_PCL = 4'h0;
  localparam logic [3:0] PSS_OFF_STATUS = 4'h1;
  localparam int PSS_STATUS_IRQ_BIT = 0;
  localparam int PSS_STATUS_VALID_BIT = 1;
  localparam int PSS_STATUS_PCL_PEND_BIT = 2;

  typedef enum logic [2:0] {
    PSS_OP_NONE,
    PSS_OP_JUMP,
    PSS_OP_CALL,
    PSS_OP_RET,
    PSS_OP_INTERRUPT_RETURN,
    PSS_OP_SKIP
  } pss_op_t;
endpackage
`default_nettype wire

// file: hdl/pss_stack_if.sv
// Connection between the sequencer and its return stack
`default_nettype none
interface pss_stack_if;
  import pss_pkg::*;
  logic push;
  logic pop;
  logic [PSS_PC_W-1:0] push_data;
  logic [PSS_PC_W-1:0] top_data;
  logic full;
  logic empty;
  modport seq (output push, output pop, output push_data, input top_data, input full,
    input empty);
  modport stk (input push, input pop, input push_data, output top_data, output full,
    output empty);
endinterface
`default_nettype wire

// file: hdl/pss_stack.sv
// Eight-level hardware return stack holding program counter values
`default_nettype none
module pss_stack
  import pss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  pss_stack_if.stk stk
);
  logic [PSS_PC_W-1:0] mem_q [PSS_STK_DEPTH];
  logic [PSS_STK_PTR_W-1:0] top_q;
  logic [PSS_STK_CNT_W-1:0] cnt_q;
  wire [PSS_STK_PTR_W-1:0] next_top = top_q + 3'h1;
  wire [PSS_STK_PTR_W-1:0] prev_top = top_q - 3'h1;

  assign stk.full = (cnt_q == PSS_STK_CNT_FULL);
  assign stk.empty = (cnt_q == PSS_STK_CNT_RESET);
  assign stk.top_data = mem_q[top_q];

  // Circular storage: a push when full overwrites the oldest entry
  always_ff @(posedge core_clk) begin
    if (stk.push) begin
      mem_q[next_top] <= stk.push_data; // RULE12 RULE16
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      top_q <= PSS_STK_TOP_RESET; // RULE14
      cnt_q <= PSS_STK_CNT_RESET; // RULE14
    end else if (stk.push) begin
      top_q <= next_top;
      cnt_q <= stk.full ? cnt_q : cnt_q + 4'h1; // RULE16
    end else if (stk.pop && !stk.empty) begin
      top_q <= prev_top; // RULE13
      cnt_q <= cnt_q - 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_reset_empty;
    $rose(rst_n) |-> stk.empty;
  endproperty
  a_reset_empty: assert property (p_reset_empty) else $error("stack not empty after reset"); // RULE14

  property p_overflow_stays_full;
    stk.full && stk.push |=> stk.full && stk.top_data == $past(stk.push_data);
  endproperty
  a_overflow_stays_full: assert property (p_overflow_stays_full) // RULE16
    else $error("push on full stack lost data or count");

  // Requests arrive at instruction-cycle ends, so a call's earliest return is eight clocks on
  sequence s_push_then_pop;
    stk.push ##1 (!stk.push && !stk.pop) [*7] ##1 (stk.pop && !stk.push);
  endsequence
  property p_pop_returns_last;
    s_push_then_pop |-> stk.top_data == $past(stk.push_data, 8);
  endproperty
  a_pop_returns_last: assert property (p_pop_returns_last) // RULE13
    else $error("pop does not return last pushed value");
endmodule
`default_nettype wire

// file: hdl/pss_sequencer.sv
// Program sequencer: phase generator, program counter, fetch pipeline, stack control
// Operation
// (RULE1) Four non-overlapping phases from the system clock form one instruction cycle.
// (RULE2) Phase one advances the program counter and fetches the next word.
// (RULE3) Phases two to four decode and execute the previously fetched word.
// (RULE4) Fetch overlaps execute, giving one plain instruction per cycle.
// (RULE5) Counter-changing instructions cost one extra cycle before the branch lands.
// (RULE6) Sequential flow adds exactly one to the counter each instruction.
// (RULE7) Jump, call, interrupt and reset load the target straight into the counter.
// (RULE8) A taken skip discards the prefetched word and runs a dummy cycle.
// (RULE9) Counter is 12 bits; only the low byte is software visible.
// (RULE10) Low byte write jumps within the current 256-word page with a dummy cycle.
// (RULE11) Eight-entry return stack, neither entries nor pointer software visible.
// (RULE12) Call or interrupt acknowledge pushes the counter onto the stack.
// (RULE13) Subroutine or interrupt return pops the top entry into the counter.
// (RULE14) Reset sets the stack pointer to the top, stack empty.
// (RULE15) Full stack defers interrupt acknowledge until a return frees an entry.
// (RULE16) A call on a full stack proceeds and loses the oldest entry.
// (RULE17) After reset fetching begins at address zero.
// (RULE18) A call pushes the address of the instruction after the call.
`default_nettype none
module pss_sequencer
  import pss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [11:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [15:0] pmem_data,
  output logic [3:0] instruction_phase_clocks,
  output logic [15:0] instr_word,
  output logic instr_valid,
  input wire logic [2:0] exec_op,
  input wire logic [11:0] exec_target,
  input wire logic irq_req,
  input wire logic [11:0] irq_vector,
  output logic irq_ack
);
  pss_stack_if stk_if ();

  pss_stack u_stack (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .stk(stk_if.stk)
  );

  logic [3:0] phase_q;
  logic [PSS_PC_W-1:0] pc_q;
  logic [PSS_PC_W-1:0] fetch_addr_q;
  logic [PSS_INSTR_W-1:0] fetch_word_q;
  logic [PSS_INSTR_W-1:0] instr_q;
  logic valid_q;
  // Nothing has been fetched before the first cycle after reset, so that cycle is a dummy
  logic primed_q;
  logic irq_pend_q;
  logic irq_ack_q;
  logic pcl_pend_q;
  logic [PSS_PCL_W-1:0] pcl_data_q;
  logic [7:0] rdata_q;

  // Decode of the instruction finishing at the end of phase four
  wire cycle_end = phase_q[3];
  wire [2:0] op = valid_q ? exec_op : 3'(PSS_OP_NONE);
  wire is_jump = (op == 3'(PSS_OP_JUMP));
  wire is_call = (op == 3'(PSS_OP_CALL));
  wire is_ret = (op == 3'(PSS_OP_RET)) || (op == 3'(PSS_OP_INTERRUPT_RETURN));
  wire is_skip = (op == 3'(PSS_OP_SKIP));
  wire branch = is_jump || is_call || is_ret || is_skip;

  // Register decode
  wire wr_pcl = reg_wr && (reg_addr == PSS_OFF_PCL);
  wire rd_pcl = reg_rd && (reg_addr == PSS_OFF_PCL);
  wire rd_status = reg_rd && (reg_addr == PSS_OFF_STATUS);
  wire [7:0] status_word = {5'h00, pcl_pend_q, valid_q, irq_pend_q};

  // A low-byte write waits for the end of the instruction cycle; a branch then wins
  wire pcl_want = pcl_pend_q || wr_pcl;
  wire [PSS_PCL_W-1:0] pcl_val = wr_pcl ? reg_wdata : pcl_data_q;
  wire pcl_take = pcl_want && !branch;
  wire irq_take = irq_pend_q && !stk_if.full && !branch && !pcl_take; // RULE15
  wire redirect = branch || pcl_take || irq_take;

  // Next fetch address chosen at the end of each instruction cycle
  wire [PSS_PC_W-1:0] pcl_target = {pc_q[11:8], pcl_val}; // RULE9 RULE10
  wire [PSS_PC_W-1:0] new_pc = (is_jump || is_call) ? exec_target : // RULE7
                               is_ret ? stk_if.top_data : // RULE13
                               pcl_take ? pcl_target : // RULE10
                               irq_take ? irq_vector : // RULE7
                               pc_q; // RULE6 RULE8
  wire [PSS_PC_W-1:0] pc_inc = new_pc + 12'h001;

  // Stack control; the word after the executing one is the fetched address
  assign stk_if.push = cycle_end && (is_call || irq_take); // RULE12 RULE16
  assign stk_if.pop = cycle_end && is_ret; // RULE13
  assign stk_if.push_data = fetch_addr_q; // RULE18

  // Four-phase generator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PSS_PH_RESET;
    end else begin
      phase_q <= {phase_q[2:0], phase_q[3]}; // RULE1
    end
  end

  // Program counter and fetch address; both move on entering phase one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= PSS_RESET_VECTOR; // RULE17
      fetch_addr_q <= PSS_RESET_VECTOR; // RULE17
    end else if (cycle_end) begin
      fetch_addr_q <= new_pc; // RULE2
      pc_q <= pc_inc; // RULE2 RULE6
    end
  end

  // Fetch buffer filled at the end of phase two, handed to execute at cycle end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_word_q <= PSS_INSTR_RESET;
      instr_q <= PSS_INSTR_RESET;
      valid_q <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      if (phase_q[1]) begin
        fetch_word_q <= pmem_data; // RULE4
      end
      if (cycle_end) begin
        instr_q <= fetch_word_q; // RULE3 RULE4
        valid_q <= primed_q && !redirect; // RULE5 RULE8 RULE10 RULE17
        primed_q <= 1'b1;
      end
    end
  end

  // Interrupt request latch; a new request wins over the acknowledge clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend_q <= 1'b0;
      irq_ack_q <= 1'b0;
    end else begin
      irq_pend_q <= irq_req || (irq_pend_q && !(cycle_end && irq_take)); // RULE15
      irq_ack_q <= cycle_end && irq_take; // RULE12 RULE15
    end
  end

  // Low-byte write capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcl_pend_q <= 1'b0;
      pcl_data_q <= PSS_PCL_RESET;
    end else begin
      pcl_pend_q <= pcl_want && !(cycle_end && pcl_take); // RULE10
      if (wr_pcl) begin
        pcl_data_q <= reg_wdata;
      end
    end
  end

  // Read data one cycle after the strobe; stack state is never readable
  wire [7:0] rdata_d = rd_pcl ? pc_q[7:0] : rd_status ? status_word : 8'h00; // RULE9 RULE11
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pmem_addr = fetch_addr_q;
  assign pmem_rd = phase_q[0]; // RULE2
  assign instruction_phase_clocks = phase_q; // RULE1
  assign instr_word = instr_q;
  assign instr_valid = valid_q;
  assign irq_ack = irq_ack_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_four_phases;
    phase_q == PSS_PH_T1 ##1 phase_q == PSS_PH_T2 ##1 phase_q == PSS_PH_T3
      ##1 phase_q == PSS_PH_T4;
  endsequence
  property p_phase_cycle;
    phase_q == PSS_PH_T1 |-> s_four_phases;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken"); // RULE1

  property p_fetch_at_t1;
    cycle_end |=> pmem_rd && pmem_addr == $past(new_pc) && pc_q == $past(new_pc) + 12'h001;
  endproperty
  a_fetch_at_t1: assert property (p_fetch_at_t1) else $error("fetch not at phase one"); // RULE2

  property p_sequential;
    cycle_end && !redirect && primed_q |=> pmem_addr == $past(pc_q) && instr_valid;
  endproperty
  a_sequential: assert property (p_sequential) else $error("sequential step wrong"); // RULE6

  sequence s_dummy_cycle;
    !instr_valid [*4];
  endsequence
  property p_branch_dummy;
    cycle_end && (is_jump || is_call) |=> pmem_addr == $past(exec_target) ##0 s_dummy_cycle;
  endproperty
  a_branch_dummy: assert property (p_branch_dummy) else $error("branch timing wrong"); // RULE5

  property p_skip_discard;
    cycle_end && is_skip |=> pmem_addr == $past(pc_q) ##0 s_dummy_cycle;
  endproperty
  a_skip_discard: assert property (p_skip_discard) else $error("skip did not discard"); // RULE8

  property p_pcl_page_jump;
    cycle_end && pcl_take |=> pmem_addr == {$past(pc_q[11:8]), $past(pcl_val)} && !instr_valid;
  endproperty
  a_pcl_page_jump: assert property (p_pcl_page_jump) else $error("low byte jump wrong"); // RULE10

  property p_call_push;
    cycle_end && is_call |=> stk_if.top_data == $past(pmem_addr) && !stk_if.empty;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call did not push next address"); // RULE18

  property p_irq_held_when_full;
    stk_if.full && irq_pend_q |=> !irq_ack;
  endproperty
  a_irq_held_when_full: assert property (p_irq_held_when_full) // RULE15
    else $error("interrupt acknowledged on full stack");

  property p_irq_vector;
    irq_ack |-> pmem_addr == $past(irq_vector) && !instr_valid;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("interrupt entry address wrong"); // RULE7

  property p_return_pop;
    cycle_end && is_ret |=> pmem_addr == $past(stk_if.top_data);
  endproperty
  a_return_pop: assert property (p_return_pop) else $error("return address wrong"); // RULE13

  property p_reset_fetch;
    $rose(rst_n) |=> pmem_rd && pmem_addr == PSS_RESET_VECTOR && !instr_valid;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("first fetch not at zero"); // RULE17

  property p_phase_onehot;
    $onehot(phase_q);
  endproperty
  a_phase_onehot: assert property (p_phase_onehot) // RULE1
    else $error("phases not one-hot");

  property p_addr_stands;
    !cycle_end |=> $stable(pmem_addr);
  endproperty
  a_addr_stands: assert property (p_addr_stands) // RULE2
    else $error("fetch address moved inside a cycle");

  property p_fetch_strobe;
    cycle_end |=> pmem_rd ##1 (!pmem_rd) [*3];
  endproperty
  a_fetch_strobe: assert property (p_fetch_strobe) // RULE2
    else $error("fetch strobe misplaced");

  property p_instr_stands;
    !cycle_end |=> $stable(instr_word) && $stable(instr_valid);
  endproperty
  a_instr_stands: assert property (p_instr_stands) // RULE3
    else $error("executing word moved inside a cycle");

  property p_rdata_pcl;
    rd_pcl |=> reg_rdata == $past(pc_q[7:0]);
  endproperty
  a_rdata_pcl: assert property (p_rdata_pcl) // RULE9
    else $error("low byte read wrong");

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RULE9
    else $error("read data not cleared");

  property p_rdata_unmapped;
    reg_rd && !rd_pcl && !rd_status |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) // RULE11
    else $error("unmapped read not zero");

  property p_pcl_pending;
    wr_pcl && !cycle_end |=> pcl_pend_q;
  endproperty
  a_pcl_pending: assert property (p_pcl_pending) // RULE10
    else $error("low byte write not held pending");

  property p_ack_pulse;
    irq_ack |=> !irq_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) // RULE12
    else $error("acknowledge longer than one cycle");

  property p_call_on_full;
    cycle_end && is_call && stk_if.full |=> stk_if.full && pmem_addr == $past(exec_target);
  endproperty
  a_call_on_full: assert property (p_call_on_full) // RULE16
    else $error("call on full stack did not proceed");

  sequence s_ret_pending;
    cycle_end && is_ret && irq_pend_q && stk_if.full;
  endsequence
  property p_irq_after_return;
    s_ret_pending ##4 !pcl_want |=> irq_ack;
  endproperty
  a_irq_after_return: assert property (p_irq_after_return) // RULE15
    else $error("deferred interrupt not served after return");
endmodule
`default_nettype wire

// file: sim/pss_pmem_model.sv
// Program memory model answering the sequencer's fetch strobe
`default_nettype none
module pss_pmem_model (
  input wire logic core_clk,
  input wire logic [11:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [15:0] pmem_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pmem_data = 16'h0000;
  // Word valid only in the cycle after the strobe, toggling otherwise
  always @(posedge core_clk) begin
    if (pmem_rd) begin
      pmem_data <= {~pmem_addr[11:8], pmem_addr};
    end else begin
      pmem_data <= ~pmem_data;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the program sequencer
`default_nettype none
module tb;
  import pss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, reg_wr, reg_rd, pmem_rd, instr_valid, irq_req, irq_ack;
  logic [3:0] reg_addr, instruction_phase_clocks;
  logic [7:0] reg_wdata, reg_rdata;
  logic [11:0] pmem_addr, exec_target, irq_vector, f;
  logic [15:0] pmem_data, instr_word;
  logic [2:0] exec_op;
  logic ev, pend;
  logic [11:0] stk[$];
  int errors = 0;
  int tests_run = 0;
  int seed = 32'h6ec298d4;

  pss_sequencer dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pmem_addr, .pmem_rd, .pmem_data, .instruction_phase_clocks, .instr_word, .instr_valid,
    .exec_op, .exec_target, .irq_req, .irq_vector, .irq_ack);
  pss_pmem_model pmem_u (.core_clk, .pmem_addr, .pmem_rd, .pmem_data);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] word_of(input logic [11:0] a);
    return {~a[11:8], a};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (exp !== got) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("phase_in_reset", PSS_PH_RESET, instruction_phase_clocks);
    chk("valid_in_reset", 16'h0, instr_valid);
    @(posedge core_clk) rst_n <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk("phase_first", PSS_PH_T1, instruction_phase_clocks);
    chk("fetch_reset_vector", PSS_RESET_VECTOR, pmem_addr);
    chk("valid_after_reset", 16'h0, instr_valid);
    f = 12'h000;
    ev = 1'b0;
    pend = 1'b0;
    stk.delete();
  endtask

  // One instruction cycle, entered and left at the falling edge inside phase one
  task automatic cyc(input logic [2:0] op, input logic [11:0] tgt, input logic irq,
    input logic [1:0] k, input logic [3:0] a, input logic [7:0] d);
    logic take, pclw, ack;
    logic [11:0] na, nf;
    logic [7:0] rexp;
    nf = f + 12'h001;
    rexp = (a == PSS_OFF_PCL) ? nf[7:0] : (a == PSS_OFF_STATUS) ? {6'h00, ev, pend} : 8'h00;
    @(posedge core_clk) begin
      exec_op <= op;
      exec_target <= tgt;
      irq_req <= irq;
      reg_wr <= (k == 2'd1);
      reg_rd <= (k == 2'd2);
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge core_clk) begin
      irq_req <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
    @(negedge core_clk);
    if (k == 2'd2) chk("reg_rdata", rexp, reg_rdata);
    repeat (2) @(negedge core_clk);
    pend = pend | irq;
    take = ev && (op != PSS_OP_NONE);
    pclw = !take && (k == 2'd1) && (a == PSS_OFF_PCL);
    ack = !take && !pclw && pend && (stk.size() < PSS_STK_DEPTH);
    na = nf;
    if (take && (op == PSS_OP_JUMP || op == PSS_OP_CALL)) na = tgt;
    if (take && (op == PSS_OP_RET || op == PSS_OP_INTERRUPT_RETURN)) na = stk.pop_back();
    if ((take && op == PSS_OP_CALL) || ack) stk.push_back(f);
    if (stk.size() > PSS_STK_DEPTH) stk.pop_front();
    if (pclw) na = {nf[11:8], d};
    if (ack) na = irq_vector;
    if (ack) pend = 1'b0;
    chk("fetch_addr", na, pmem_addr);
    chk("instr_valid", !(take || pclw || ack), instr_valid);
    chk("irq_ack", ack, irq_ack);
    if (!(take || pclw || ack)) chk("instr_word", word_of(f), instr_word);
    f = na;
    ev = !(take || pclw || ack);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    logic [31:0] r;
    logic [2:0] op;
    rst_n = 1'b0;
    {reg_wr, reg_rd, irq_req} = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    exec_op = PSS_OP_NONE;
    exec_target = 12'h000;
    irq_vector = 12'($random(seed));
    do_reset;
    for (int i = 0; i < 8; i++) begin
      chk("phase", 4'h1 << (i % 4), instruction_phase_clocks);
      chk("fetch_strobe", (i % 4) == 0, pmem_rd);
      @(negedge core_clk);
    end
    f = 12'h002;
    ev = 1'b1;
    repeat (3) cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    done("sequential");
    cyc(PSS_OP_JUMP, 12'h0fe, 1'b0, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_SKIP, 12'h000, 1'b0, 2'd2, PSS_OFF_PCL, 8'h00);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd1, PSS_OFF_PCL, 8'($random(seed)));
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd1, PSS_OFF_STATUS, 8'hff);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd2, PSS_OFF_STATUS, 8'h00);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd2, 4'h9, 8'h00);
    done("branch_and_register");
    repeat (9) begin
      cyc(PSS_OP_CALL, 12'($random(seed)), 1'b0, 2'd0, 4'h0, 8'h00);
      cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    end
    cyc(PSS_OP_NONE, 12'h000, 1'b1, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_RET, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_INTERRUPT_RETURN, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    repeat (7) begin
      cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
      cyc(PSS_OP_RET, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    end
    done("stack");
    repeat (60) begin
      r = $random(seed);
      op = (r[2:0] > 3'd5) ? 3'd0 : r[2:0];
      if ((op == PSS_OP_RET || op == PSS_OP_INTERRUPT_RETURN) && stk.size() == 0) op = PSS_OP_NONE;
      cyc(op, 12'($random(seed)), 1'b0, {~|r[5:3], 1'b0}, {3'h0, r[6]}, 8'h00);
    end
    done("random");
    do_reset;
    cyc(PSS_OP_NONE, 12'h000, 1'b1, 2'd0, 4'h0, 8'h00);
    cyc(PSS_OP_NONE, 12'h000, 1'b0, 2'd0, 4'h0, 8'h00);
    done("second_reset");
    wrap_up;
  end

  initial begin
    #400000;
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
